// [lct_chk.sv]
// Port-level assertions of the link control bank
`timescale 1ns/1ns
`default_nettype none
`include "lct_defs.vh"
// ==========
module lct_chk #(parameter ADDR_W = 8) (
   input wire logic core_clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic cycle_overrun_event,
   input wire logic cycle_start_rx,
   input wire logic ar_request_context_enabled,
   input wire logic cycle_start_send,
   input wire logic phy_packet_store_enable,
   input wire logic self_id_accept,
   input wire logic sync_filter_force_out,
   input wire logic [`LCT_OFFSET_W-1:0] cycle_offset,
   input wire logic [`LCT_CYCLE_COUNT_W-1:0] cycle_count
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire rd = pready && !pwrite;
   wire ctl = paddr == `LCT_ADDR_CTRL_SET || paddr == `LCT_ADDR_CTRL_CLR;
   sequence setup_s; psel && !penable; endsequence
   sequence answer_s; pready ##1 !pready; endsequence
   AST_ANSWER: assert property (setup_s |=> answer_s)
      else $error("Setup not answered for exactly one cycle");
   AST_DECODE: assert property (rd && ctl |-> !pslverr)
      else $error("Link control alias refused");
   AST_UNMAPPED: assert property (pready && paddr == 8'h00 |-> pslverr)
      else $error("Unmapped access accepted");
   AST_FAIR_RSVD: assert property (rd && paddr == `LCT_ADDR_FAIRNESS
      |-> prdata[31:8] == 24'h000000)
      else $error("Fairness reserved bits not zero");
   AST_CTRL_RSVD: assert property (rd && ctl
      |-> (prdata & 32'hFF8FF9BF) == 32'h00000000)
      else $error("Link control reserved bits not zero");
   AST_SELF_ID: assert property (rd && ctl
      |-> prdata[9] == self_id_accept)
      else $error("Self-ID accept differs from its bit");
   AST_PHY_PKT: assert property (rd && ctl |-> phy_packet_store_enable
      == (prdata[10] && $past(ar_request_context_enabled)))
      else $error("PHY packet store enable wrong");
   AST_SYNC: assert property (rd && ctl
      |-> prdata[6] == sync_filter_force_out)
      else $error("Sync filter force output differs from its bit");
   AST_OVERRUN: assert property (cycle_overrun_event [*4]
      |-> !cycle_start_send)
      else $error("Cycle start sent during overrun");
   AST_ADVANCE: assert property ($changed(cycle_offset) && cycle_offset != 0
      |-> cycle_offset == $past(cycle_offset) + 1)
      else $error("Offset did not step by one");
   AST_COUNT: assert property ($changed(cycle_count) && !$past(cycle_start_rx)
      && !$past(cycle_start_rx, 2)
      |-> cycle_count == $past(cycle_count) + 1)
      else $error("Cycle count did not step by one");
   AST_MAX: assert property (cycle_offset <= 12'hBFF)
      else $error("Offset passed 3071");
endmodule // lct_chk
bind lct_link_ctrl lct_chk #(.ADDR_W(ADDR_W)) lct_chk_inst (
   .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .cycle_overrun_event(cycle_overrun_event),
   .cycle_start_rx(cycle_start_rx),
   .ar_request_context_enabled(ar_request_context_enabled),
   .cycle_start_send(cycle_start_send),
   .phy_packet_store_enable(phy_packet_store_enable),
   .self_id_accept(self_id_accept),
   .sync_filter_force_out(sync_filter_force_out),
   .cycle_offset(cycle_offset), .cycle_count(cycle_count));
`default_nettype wire

// [lct_defs.vh]
// Register map, field positions and timing constants of the link control bank
`ifndef LCT_DEFS_VH
`define LCT_DEFS_VH

// ==========================================================================
// Register byte offsets
`define LCT_ADDR_FAIRNESS 8'hDC
`define LCT_ADDR_CTRL_SET 8'hE0
`define LCT_ADDR_CTRL_CLR 8'hE4
`define LCT_ADDR_CYCLE_TIMER 8'hF0

// ==========================================================================
// Link control bit positions
`define LCT_BIT_EXT_ROLLOVER 22
`define LCT_BIT_ROOT_CYCLE 21
`define LCT_BIT_COUNT_ENABLE 20
`define LCT_BIT_PHY_PKT_RX 10
`define LCT_BIT_SELF_ID_RX 9
`define LCT_BIT_SYNC_FORCE 6

// ==========================================================================
// Fairness field and reset values
`define LCT_PRI_REQ_MSB 7
`define LCT_PRI_REQ_RESET 8'h00
`define LCT_CTRL_RESET 1'b0
`define LCT_ZERO_WORD 32'h00000000

// ==========================================================================
// Cycle timer: 125 us at a 24.576 MHz link clock
`define LCT_CYCLE_PERIOD_US 125
`define LCT_LINK_CLK_KHZ 24576
`define LCT_OFFSET_W 12
`define LCT_CYCLE_COUNT_W 13
`define LCT_OFFSET_ZERO 12'h000
`define LCT_CYCLE_COUNT_ZERO 13'h0000

`endif

// [lct_link_ctrl.v]
// Link control registers, fairness limiter and cycle timer with APB access
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "lct_defs.vh"

// ==========================================================================
// Summary of operation
// R01: Fairness bits 31..8 read as zero
// R02: Priority requests per interval capped by limit
// R03: Priority request limit resets to zero
// R04: Link control decoded at set and clear aliases
// R05: Ones set or clear; zeros keep; reads current
// R06: Reserved link control bits read as zero
// R07: External select rolls timer on external input
// R08: Otherwise roll over after 3072 link clocks
// R09: Root sends cycle start at every rollover
// R10: Non-root syncs timer to received cycle starts
// R11: Cycle overrun event clears root bit
// R12: Root set ignored while overrun flag set
// R13: Count enable advances offset, else holds still; a cycle start received while non-root still zeroes it
// R14: PHY packets stored when enabled and context on
// R15: Self-ID enable accepts self-ID packets
// R16: Software loads self-ID pointer before enabling
// R17: Force bit holds sync tag filter at one
// R18: Force bit set-only; global reset clears it

module lct_link_ctrl #(
   parameter ADDR_W = 8
) (
   input wire core_clk,
   input wire resetn,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // Link side, asynchronous pins
   input wire link_clk_in,
   input wire external_cycle_input,
   // Link side, same clock domain
   input wire cycle_overrun_event,
   input wire cycle_start_rx,
   input wire [`LCT_CYCLE_COUNT_W-1:0] rx_cycle_count,
   input wire ar_request_context_enabled,
   input wire fairness_interval_start,
   input wire pri_req_made,
   output reg pri_req_allowed,
   output reg cycle_start_send,
   output reg cycle_rollover,
   output reg phy_packet_store_enable,
   output reg self_id_accept,
   output reg sync_filter_force_out,
   output reg [`LCT_OFFSET_W-1:0] cycle_offset,
   output reg [`LCT_CYCLE_COUNT_W-1:0] cycle_count
);

   localparam integer OFS_TICKS =
      `LCT_CYCLE_PERIOD_US * `LCT_LINK_CLK_KHZ / 1000;
   localparam integer OFS_LAST_I = OFS_TICKS - 1;
   localparam [`LCT_OFFSET_W-1:0] OFS_LAST = OFS_LAST_I[`LCT_OFFSET_W-1:0];

   // =======================================================================
   // Control state
   reg [`LCT_PRI_REQ_MSB:0] pri_req_limit;
   reg [`LCT_PRI_REQ_MSB:0] pri_req_used;
   reg external_rollover_select;
   reg root_cycle_generator;
   reg cycle_offset_count_enable;
   reg phy_packet_receive_enable;
   reg self_id_receive_enable;
   reg sync_filter_force;
   reg overrun_seen;

   // =======================================================================
   // Pin synchronisers; first stage feeds only the second
   reg lclk_s1, lclk_s2, lclk_s3;
   reg ext_s1, ext_s2, ext_s3;
   wire link_tick;
   wire ext_event;

   always @(posedge core_clk) begin
      if (!resetn) begin
         lclk_s1 <= 1'b0;
         lclk_s2 <= 1'b0;
         lclk_s3 <= 1'b0;
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
      end else begin
         lclk_s1 <= link_clk_in;
         lclk_s2 <= lclk_s1;
         lclk_s3 <= lclk_s2;
         ext_s1 <= external_cycle_input;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   // Link clock is far below core_clk, so its rising edge is a tick
   assign link_tick = lclk_s2 & ~lclk_s3;
   assign ext_event = ext_s2 & ~ext_s3;

   // =======================================================================
   // APB decode
   wire setup_phase;
   wire wr_commit;
   wire hit_fair, hit_set, hit_clr, hit_timer, hit_any;
   wire [31:0] ctrl_word;
   wire [31:0] timer_word;
   wire overrun_rise;

   assign setup_phase = psel & ~penable;
   assign wr_commit = psel & penable & pready & pwrite & ~pslverr;
   assign hit_fair = (paddr == `LCT_ADDR_FAIRNESS);
   assign hit_set = (paddr == `LCT_ADDR_CTRL_SET);   // R04
   assign hit_clr = (paddr == `LCT_ADDR_CTRL_CLR);   // R04
   assign hit_timer = (paddr == `LCT_ADDR_CYCLE_TIMER);
   assign hit_any = hit_fair | hit_set | hit_clr | hit_timer;
   assign overrun_rise = cycle_overrun_event & ~overrun_seen;

   // Only implemented bits placed; the rest stay zero
   assign ctrl_word = {9'h000,
                       external_rollover_select,
                       root_cycle_generator,
                       cycle_offset_count_enable,
                       9'h000,
                       phy_packet_receive_enable,
                       self_id_receive_enable,
                       2'h0,
                       sync_filter_force,
                       6'h00};   // R06
   assign timer_word = {7'h00, cycle_count, cycle_offset};

   // No wait state: answer is prepared in setup, given in the first access cycle
   always @(posedge core_clk) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= `LCT_ZERO_WORD;
      end else if (setup_phase) begin
         pready <= 1'b1;
         pslverr <= ~hit_any | (pwrite & hit_timer);
         if (pwrite || !hit_any)
            prdata <= `LCT_ZERO_WORD;
         else if (hit_fair)
            prdata <= {24'h000000, pri_req_limit};   // R01
         else if (hit_timer)
            prdata <= timer_word;
         else
            prdata <= ctrl_word;   // R05
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // =======================================================================
   // Fairness limit register and per-interval request budget
   always @(posedge core_clk) begin
      if (!resetn) begin
         pri_req_limit <= `LCT_PRI_REQ_RESET;   // R03
         pri_req_used <= `LCT_PRI_REQ_RESET;
         pri_req_allowed <= 1'b0;
      end else begin
         if (wr_commit && hit_fair)
            pri_req_limit <= pwdata[`LCT_PRI_REQ_MSB:0];
         if (fairness_interval_start)
            pri_req_used <= `LCT_PRI_REQ_RESET;
         else if (pri_req_made && pri_req_allowed)
            pri_req_used <= pri_req_used + 8'h01;
         // Budget check runs a cycle behind; a request made the same
         // cycle as the last grant sees the old value, so cap by count
         if (fairness_interval_start)
            pri_req_allowed <= (pri_req_limit != 8'h00);   // R02
         else if (pri_req_made && pri_req_allowed)
            pri_req_allowed <= (pri_req_used + 8'h01 < pri_req_limit);   // R02
         else
            pri_req_allowed <= (pri_req_used < pri_req_limit);   // R02
      end
   end

   // =======================================================================
   // Link control set/clear bits
   always @(posedge core_clk) begin
      if (!resetn) begin
         external_rollover_select <= `LCT_CTRL_RESET;
         root_cycle_generator <= `LCT_CTRL_RESET;
         cycle_offset_count_enable <= `LCT_CTRL_RESET;
         phy_packet_receive_enable <= `LCT_CTRL_RESET;
         self_id_receive_enable <= `LCT_CTRL_RESET;
         sync_filter_force <= `LCT_CTRL_RESET;   // R18
         overrun_seen <= 1'b0;
      end else begin
         overrun_seen <= cycle_overrun_event;
         if (wr_commit && hit_set) begin
            if (pwdata[`LCT_BIT_EXT_ROLLOVER])
               external_rollover_select <= 1'b1;   // R05
            if (pwdata[`LCT_BIT_COUNT_ENABLE])
               cycle_offset_count_enable <= 1'b1;   // R05
            if (pwdata[`LCT_BIT_PHY_PKT_RX])
               phy_packet_receive_enable <= 1'b1;   // R05
            if (pwdata[`LCT_BIT_SELF_ID_RX])
               self_id_receive_enable <= 1'b1;   // R05
            if (pwdata[`LCT_BIT_SYNC_FORCE])
               sync_filter_force <= 1'b1;   // R18
         end
         if (wr_commit && hit_clr) begin
            if (pwdata[`LCT_BIT_EXT_ROLLOVER])
               external_rollover_select <= 1'b0;   // R05
            if (pwdata[`LCT_BIT_COUNT_ENABLE])
               cycle_offset_count_enable <= 1'b0;   // R05
            if (pwdata[`LCT_BIT_PHY_PKT_RX])
               phy_packet_receive_enable <= 1'b0;   // R05
            if (pwdata[`LCT_BIT_SELF_ID_RX])
               self_id_receive_enable <= 1'b0;   // R05
         end
         // Hardware clear on overrun outranks any software write
         if (overrun_rise)
            root_cycle_generator <= 1'b0;   // R11
         else if (wr_commit && hit_clr && pwdata[`LCT_BIT_ROOT_CYCLE])
            root_cycle_generator <= 1'b0;   // R05
         else if (wr_commit && hit_set && pwdata[`LCT_BIT_ROOT_CYCLE]
                  && !cycle_overrun_event)
            root_cycle_generator <= 1'b1;   // R12
      end
   end

   // =======================================================================
   // Cycle timer
   wire internal_roll;
   wire roll_now;

   assign internal_roll = link_tick & (cycle_offset == OFS_LAST);   // R08
   assign roll_now = cycle_offset_count_enable &
                     (external_rollover_select ? ext_event : internal_roll);

   always @(posedge core_clk) begin
      if (!resetn) begin
         cycle_offset <= `LCT_OFFSET_ZERO;
         cycle_count <= `LCT_CYCLE_COUNT_ZERO;
         cycle_start_send <= 1'b0;
         cycle_rollover <= 1'b0;
      end else begin
         cycle_rollover <= roll_now;
         cycle_start_send <= roll_now & root_cycle_generator;   // R09
         if (cycle_start_rx && !root_cycle_generator) begin
            cycle_count <= rx_cycle_count;   // R10
            cycle_offset <= `LCT_OFFSET_ZERO;   // R10
         end else if (roll_now) begin
            cycle_offset <= `LCT_OFFSET_ZERO;   // R07
            cycle_count <= cycle_count + 13'h0001;
         end else if (cycle_offset_count_enable && link_tick &&
                      cycle_offset != OFS_LAST) begin
            cycle_offset <= cycle_offset + 12'h001;   // R13
         end
      end
   end

   // =======================================================================
   // Receiver and isochronous filter controls
   always @(posedge core_clk) begin
      if (!resetn) begin
         phy_packet_store_enable <= 1'b0;
         self_id_accept <= 1'b0;
         sync_filter_force_out <= 1'b0;
      end else begin
         phy_packet_store_enable <= phy_packet_receive_enable &
                                    ar_request_context_enabled;   // R14
         // Software must have loaded the buffer pointer already
         self_id_accept <= self_id_receive_enable;   // R15 R16
         sync_filter_force_out <= sync_filter_force;   // R17
      end
   end

endmodule // lct_link_ctrl
`default_nettype wire

// [lct_link_ctrl_test.sv]
// Self-checking bench of the link control bank
`timescale 1ns/1ns
`default_nettype none
`include "lct_defs.vh"
module lct_link_ctrl_test;
   logic core_clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, ext = 1'b0, ovr = 1'b0, csr = 1'b0, ctx = 1'b1;
   logic fis = 1'b0, want = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [12:0] rxc = 13'h0000;
   logic [31:0] pwdata = 32'h00000000, rd;
   wire [31:0] prdata;
   wire pready, pslverr, lclk, made, allowed, send, roll, phy_en, sid, sync;
   wire [11:0] offs;
   wire [12:0] cnt;
   integer fail_count = 0, n_tests = 0, seed = 25, ctrl_m = 0, fair_m = 0;
   integer i, k, base, lim, sent_n = 0, req_n = 0;
   lct_link_ctrl lct_link_ctrl_inst (.core_clk(core_clk), .resetn(resetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .link_clk_in(lclk), .external_cycle_input(ext),
      .cycle_overrun_event(ovr), .cycle_start_rx(csr), .rx_cycle_count(rxc),
      .ar_request_context_enabled(ctx), .fairness_interval_start(fis),
      .pri_req_made(made), .pri_req_allowed(allowed),
      .cycle_start_send(send), .cycle_rollover(roll),
      .phy_packet_store_enable(phy_en), .self_id_accept(sid),
      .sync_filter_force_out(sync), .cycle_offset(offs), .cycle_count(cnt));
   lct_phy_model lct_phy_model_inst (.core_clk(core_clk), .want_req(want),
      .pri_req_allowed(allowed), .link_clk_in(lclk), .pri_req_made(made));
   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      if (made === 1'b1) req_n <= req_n + 1;
      if (send === 1'b1) sent_n <= sent_n + 1;
   end
   // ==========
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      do @(posedge core_clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Root bit cannot be set while the overrun flag stands
      if (w && a == `LCT_ADDR_FAIRNESS) fair_m = d & 32'hFF;
      if (w && a == `LCT_ADDR_CTRL_SET)
         ctrl_m |= d & (ovr ? 32'h00500640 : 32'h00700640);
      if (w && a == `LCT_ADDR_CTRL_CLR) ctrl_m &= ~(d & 32'h00700600);
   endtask
   task automatic rdc(input logic [7:0] a);
      apb(1'b0, a, 32'h00000000);
      chk("read data", rd, a == `LCT_ADDR_FAIRNESS ? fair_m
         : (a[7:4] == 4'hE ? ctrl_m : 0));
   endtask
   task report_and_stop;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      #400000;
      fail_count++;
      report_and_stop;
   end
   // ==========
   initial begin
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      rdc(`LCT_ADDR_FAIRNESS);
      rdc(`LCT_ADDR_CTRL_SET);
      rdc(8'h00);
      chk("slave error", err, 1);
      apb(1'b1, `LCT_ADDR_FAIRNESS, $random(seed));
      rdc(`LCT_ADDR_FAIRNESS);
      apb(1'b1, `LCT_ADDR_CTRL_SET, $random(seed));
      rdc(`LCT_ADDR_CTRL_CLR);
      apb(1'b1, `LCT_ADDR_CTRL_CLR, $random(seed));
      rdc(`LCT_ADDR_CTRL_SET);
      apb(1'b1, `LCT_ADDR_CTRL_SET, 32'h00000640);
      rdc(`LCT_ADDR_CTRL_SET);
      chk("phy store enable", phy_en, 1);
      chk("self-ID accept", sid, 1);
      ctx <= 1'b0;
      repeat (2) @(posedge core_clk);
      chk("phy store context off", phy_en, 0);
      ctx <= 1'b1;
      apb(1'b1, `LCT_ADDR_CTRL_CLR, 32'hFFFFFFFF);
      rdc(`LCT_ADDR_CTRL_SET);
      chk("sync force output", sync, 1);
      for (k = 0; k < 2; k++) begin
         lim = k ? 1 + ($random(seed) & 7) : 0;
         apb(1'b1, `LCT_ADDR_FAIRNESS, lim);
         @(posedge core_clk) fis <= 1'b1;
         @(posedge core_clk) fis <= 1'b0;
         base = req_n;
         want <= 1'b1;
         repeat (100) @(posedge core_clk);
         want <= 1'b0;
         repeat (4) @(posedge core_clk);
         chk("requests", req_n - base, lim);
      end
      apb(1'b1, `LCT_ADDR_CTRL_SET, 32'h00200000);
      ovr <= 1'b1;
      ctrl_m &= ~32'h00200000;
      repeat (4) @(posedge core_clk);
      rdc(`LCT_ADDR_CTRL_SET);
      apb(1'b1, `LCT_ADDR_CTRL_SET, 32'h00200000);
      rdc(`LCT_ADDR_CTRL_SET);
      ovr <= 1'b0;
      rxc <= $random(seed);
      @(posedge core_clk) csr <= 1'b1;
      @(posedge core_clk) csr <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("loaded count", cnt, rxc);
      apb(1'b0, `LCT_ADDR_CYCLE_TIMER, 32'h00000000);
      chk("timer read", rd, {7'h00, rxc, 12'h000});
      apb(1'b1, `LCT_ADDR_CYCLE_TIMER, 32'h00000000);
      chk("timer write refused", err, 1);
      apb(1'b1, `LCT_ADDR_CTRL_SET, 32'h00300000);
      repeat (100) @(posedge core_clk);
      chk("offset moving", offs != 0, 1);
      apb(1'b1, `LCT_ADDR_CTRL_CLR, 32'h00100000);
      repeat (10) @(posedge core_clk);
      base = offs;
      repeat (100) @(posedge core_clk);
      chk("offset held", offs, base);
      @(posedge core_clk) csr <= 1'b1;
      @(posedge core_clk) csr <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("root ignores start", cnt, rxc);
      apb(1'b1, `LCT_ADDR_CTRL_SET, 32'h00100000);
      for (i = 0; i < 20000 && roll !== 1'b1; i++) @(posedge core_clk);
      repeat (3) @(posedge core_clk);
      chk("internal rollover", cnt, 13'(rxc + 13'h0001));
      chk("cycle starts sent", sent_n, 1);
      // Ext select also keeps the root bit, so a send follows too
      apb(1'b1, `LCT_ADDR_CTRL_SET, 32'h00400000);
      ext <= 1'b1;
      for (i = 0; i < 20 && roll !== 1'b1; i++) @(posedge core_clk);
      chk("external rollover", roll, 1);
      // Only a reset may drop the force bit
      resetn <= 1'b0;
      repeat (3) @(posedge core_clk);
      resetn <= 1'b1;
      ctrl_m = 0;
      fair_m = 0;
      chk("force after reset", sync, 0);
      rdc(`LCT_ADDR_CTRL_SET);
      rdc(`LCT_ADDR_FAIRNESS);
      report_and_stop;
   end
endmodule // lct_link_ctrl_test
`default_nettype wire

// [lct_phy_model.sv]
// Link clock source and requesting PHY side of the link
`timescale 1ns/1ns
`default_nettype none
module lct_phy_model (
   input wire logic core_clk,
   input wire logic want_req,
   input wire logic pri_req_allowed,
   output logic link_clk_in,
   output logic pri_req_made
);
   logic [1:0] gap = 2'h0;
   initial link_clk_in = 1'b0;
   initial pri_req_made = 1'b0;
   // Free running, near 24.576 MHz, unrelated to the core clock
   always begin
      #20 link_clk_in = 1'b1;
      #21 link_clk_in = 1'b0;
   end
   // Spaced pulses so the registered budget is seen between requests
   always @(posedge core_clk) begin
      gap <= gap + 2'h1;
      pri_req_made <= want_req && pri_req_allowed && gap == 2'h0;
   end
endmodule // lct_phy_model
`default_nettype wire
